// File: flash_seq_pkg.sv
package flash_seq_pkg;
   localparam int          ROW_WORDS     = 32;
   localparam int          IDX_W         = 5;
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          OP_TIME_MS    = 2;
   localparam int          OP_CYCLES     = OP_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int          CNT_W         = 20;
   localparam int          GO_NOPS       = 2;
   // device register offsets
   localparam logic [15:0] OFS_CTRL      = 16'h0760;
   localparam logic [15:0] OFS_ADDR_LO   = 16'h0762;
   localparam logic [15:0] OFS_ADDR_HI   = 16'h0764;
   localparam logic [15:0] OFS_KEY       = 16'h0766;
   localparam logic [15:0] RST_CTRL      = 16'h0000;
   localparam logic [7:0]  KEY_FIRST     = 8'h55;
   localparam logic [7:0]  KEY_SECOND    = 8'haa;
   // flash_op_control fields
   localparam int          CTRL_GO       = 15;
   localparam int          CTRL_PERMIT   = 14;
   localparam int          OP_ERASE_BIT  = 6;
   localparam logic [15:0] CTRL_WMASK    = 16'h417f;
   localparam logic [15:0] ADDR_HI_MASK  = 16'h00ff;
   localparam logic [3:0]  OP_ROW        = 4'h1;
   localparam logic [15:0] CMD_ERASE_ROW = 16'h4041;
   localparam logic [15:0] CMD_PROG_ROW  = 16'h4001;
   localparam logic [15:0] GO_SET        = 16'h8000;
   // controller register offsets
   localparam logic [3:0]  H_CTRL        = 4'h0;
   localparam logic [3:0]  H_ADDR_LO     = 4'h1;
   localparam logic [3:0]  H_ADDR_HI     = 4'h2;
   localparam logic [3:0]  H_DATA_LO     = 4'h3;
   localparam logic [3:0]  H_DATA_HI     = 4'h4;
   localparam logic [3:0]  H_STATUS      = 4'h5;
   localparam int          HC_ERASE      = 0;
   localparam int          HC_PROG       = 1;
   localparam int          HC_REWIND     = 2;

   typedef enum logic [1:0] {
      KEY_IDLE = 2'b00,
      KEY_HALF = 2'b01,
      KEY_OPEN = 2'b10
   } key_e;

   typedef enum logic [3:0] {
      H_IDLE   = 4'b0000,
      H_TBL_LO = 4'b0001,
      H_TBL_HI = 4'b0010,
      H_SETCON = 4'b0011,
      H_SETAHI = 4'b0100,
      H_SETALO = 4'b0101,
      H_KEY1   = 4'b0110,
      H_KEY2   = 4'b0111,
      H_GO     = 4'b1000,
      H_NOP    = 4'b1001,
      H_POLL   = 4'b1010,
      H_CHECK  = 4'b1011
   } host_e;
endpackage

// File: flash_seq_if.sv
`timescale 1ns/1ps
interface flash_seq_if;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        tbl_low;
   logic        tbl_high;
   logic [23:0] tbl_ea;
   logic [15:0] tbl_data;
   logic        stall;

   modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata, tbl_low, tbl_high, tbl_ea, tbl_data,
                output reg_rdata, stall);
   modport core (output reg_wr, reg_rd, reg_addr, reg_wdata, tbl_low, tbl_high, tbl_ea, tbl_data,
                 input reg_rdata, stall);
endinterface

// File: flash_row_core.sv
`timescale 1ns/1ps
module flash_row_core (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [3:0]  user_addr,
   input  wire logic [15:0] user_wdata,
   input  wire logic        user_wr,
   input  wire logic        user_rd,
   output logic      [15:0] user_rdata,
   flash_seq_if.core        bus
);
   import flash_seq_pkg::*;

   typedef struct packed {
      host_e       st;
      logic [15:0] base_lo;
      logic [15:0] base_hi;
      logic [15:0] data_lo;
      logic [7:0]  data_hi;
      logic [IDX_W:0] words;
      logic        erase;
      logic        done;
      logic        defer;
      logic [1:0]  nops;
      logic [15:0] urdata;
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        tlo;
      logic        thi;
      logic [23:0] ea;
      logic [15:0] tdata;
   } core_s;

   core_s s_r;
   core_s s_nxt;

   function automatic logic [23:0] word_ea(input logic [15:0] hi, input logic [15:0] lo,
                                           input logic [IDX_W:0] n);
      word_ea = {hi[7:0], lo} + {17'h00000, n, 1'b0};
   endfunction

   assign user_rdata    = s_r.urdata;
   assign bus.reg_wr    = s_r.wr;
   assign bus.reg_rd    = s_r.rd;
   assign bus.reg_addr  = s_r.addr;
   assign bus.reg_wdata = s_r.wdata;
   assign bus.tbl_low   = s_r.tlo;
   assign bus.tbl_high  = s_r.thi;
   assign bus.tbl_ea    = s_r.ea;
   assign bus.tbl_data  = s_r.tdata;

   always_comb begin
      s_nxt        = s_r;
      s_nxt.wr     = 1'b0;
      s_nxt.rd     = 1'b0;
      s_nxt.tlo    = 1'b0;
      s_nxt.thi    = 1'b0;
      s_nxt.urdata = 16'h0000;
      // ---------------------------------------------------------------
      // user register port
      // ---------------------------------------------------------------
      if (user_rd) begin
         case (user_addr)
            H_ADDR_LO: s_nxt.urdata = s_r.base_lo;
            H_ADDR_HI: s_nxt.urdata = s_r.base_hi & ADDR_HI_MASK;
            H_STATUS:  s_nxt.urdata = {7'h00, s_r.defer, s_r.done, (s_r.st != H_IDLE), s_r.words};
            default:   s_nxt.urdata = 16'h0000;
         endcase
      end
      if (user_wr && s_r.st == H_IDLE) begin
         case (user_addr)
            H_CTRL: begin
               if (user_wdata[HC_REWIND]) begin
                  s_nxt.words = '0;
               end
               if (user_wdata[HC_ERASE] || user_wdata[HC_PROG]) begin
                  s_nxt.erase = user_wdata[HC_ERASE];
                  s_nxt.done  = 1'b0;
                  s_nxt.st    = H_SETCON;
               end
            end
            H_ADDR_LO: s_nxt.base_lo = user_wdata;
            H_ADDR_HI: s_nxt.base_hi = user_wdata & ADDR_HI_MASK;
            H_DATA_LO: s_nxt.data_lo = user_wdata;
            H_DATA_HI: begin
               s_nxt.data_hi = user_wdata[7:0];
               s_nxt.st      = H_TBL_LO;
            end
            default: s_nxt.st = s_r.st;
         endcase
      end
      // ---------------------------------------------------------------
      // sequence engine, frozen while the device stalls the core
      // ---------------------------------------------------------------
      if (!bus.stall) begin
         case (s_r.st)
            H_TBL_LO: begin
               s_nxt.tlo   = 1'b1;
               s_nxt.ea    = word_ea(s_r.base_hi, s_r.base_lo, s_r.words);
               s_nxt.tdata = s_r.data_lo;
               s_nxt.st    = H_TBL_HI;
            end
            H_TBL_HI: begin
               s_nxt.thi   = 1'b1;
               s_nxt.tdata = {8'h00, s_r.data_hi};
               s_nxt.words = s_r.words + 1'b1;
               s_nxt.st    = H_IDLE;
            end
            H_SETCON: begin
               s_nxt.wr    = 1'b1;
               s_nxt.addr  = OFS_CTRL;
               s_nxt.wdata = s_r.erase ? CMD_ERASE_ROW : CMD_PROG_ROW;
               s_nxt.st    = s_r.erase ? H_SETAHI : H_KEY1;
            end
            H_SETAHI: begin
               s_nxt.wr    = 1'b1;
               s_nxt.addr  = OFS_ADDR_HI;
               s_nxt.wdata = s_r.base_hi;
               s_nxt.st    = H_SETALO;
            end
            H_SETALO: begin
               s_nxt.wr    = 1'b1;
               s_nxt.addr  = OFS_ADDR_LO;
               s_nxt.wdata = s_r.base_lo;
               s_nxt.st    = H_KEY1;
            end
            H_KEY1: begin
               s_nxt.defer = 1'b1;
               s_nxt.wr    = 1'b1;
               s_nxt.addr  = OFS_KEY;
               s_nxt.wdata = {8'h00, KEY_FIRST};
               s_nxt.st    = H_KEY2;
            end
            H_KEY2: begin
               s_nxt.wr    = 1'b1;
               s_nxt.addr  = OFS_KEY;
               s_nxt.wdata = {8'h00, KEY_SECOND};
               s_nxt.st    = H_GO;
            end
            H_GO: begin
               s_nxt.wr    = 1'b1;
               s_nxt.addr  = OFS_CTRL;
               s_nxt.wdata = (s_r.erase ? CMD_ERASE_ROW : CMD_PROG_ROW) | GO_SET;
               s_nxt.nops  = '0;
               s_nxt.st    = H_NOP;
            end
            H_NOP: begin
               s_nxt.nops = s_r.nops + 1'b1;
               if (s_r.nops == 2'(GO_NOPS - 1)) begin
                  s_nxt.defer = 1'b0;
                  s_nxt.st    = H_POLL;
               end
            end
            H_POLL: begin
               s_nxt.rd   = 1'b1;
               s_nxt.addr = OFS_CTRL;
               s_nxt.st   = H_CHECK;
            end
            H_CHECK: begin
               if (s_r.rd) begin
                  // read data arrive one cycle after the strobe
                  s_nxt.st = H_CHECK;
               end else if (bus.reg_rdata[CTRL_GO]) begin
                  s_nxt.st = H_POLL;
               end else begin
                  s_nxt.done = 1'b1;
                  s_nxt.st   = H_IDLE;
               end
            end
            H_IDLE: begin
               // starts come from the user port above
            end
            default: s_nxt.st = H_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_r    <= '0;
         s_r.st <= H_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// File: flash_row_seq.sv
`timescale 1ns/1ps
//Contract
// - one 32-word row per operation
// - controller loads row address before erase
// - keys 0x55 then 0xAA before go
// - no operation without key pair just before
// - go after unlock starts erase, core stalls
// - go with program selected starts program, stalls
// - hardware clears go at cycle end
// - latches filled by 32 low, 32 high stores
// - high store keeps only source low byte
// - low then high store, pointer increments
// - control value 0x4041 selects row erase
// - two idle instructions follow go
// - defer interrupts for five instructions
// - unimplemented register bits read zero
// - low address captures table store EA
// - each operation lasts 2 ms, core waits
module flash_row_seq #(
   parameter int OP_LEN = flash_seq_pkg::OP_CYCLES
) (
   input  wire logic                           mclk,
   input  wire logic                           rst,
   flash_seq_if.dev                            bus,
   input  wire logic [flash_seq_pkg::IDX_W-1:0] latch_idx,
   output logic      [23:0]                    latch_word,
   output logic      [23:0]                    row_addr,
   output logic                                op_erase,
   output logic                                op_program,
   output logic                                op_done
);
   import flash_seq_pkg::*;

   typedef struct packed {
      logic [15:0]                   ctrl;
      logic [15:0]                   adr_lo;
      logic [7:0]                    adr_hi;
      key_e                          key;
      logic                          busy;
      logic [CNT_W-1:0]              cnt;
      logic [ROW_WORDS-1:0][23:0]    latch;
      logic [15:0]                   rdata;
      logic [23:0]                   lword;
      logic [23:0]                   row;
      logic                          erase;
      logic                          prog;
      logic                          done;
   } dev_s;

   dev_s s_r;
   dev_s s_nxt;

   function automatic logic [IDX_W-1:0] ea_index(input logic [23:0] ea);
      ea_index = ea[IDX_W:1];
   endfunction

   function automatic logic [23:0] row_base(input logic [7:0] hi, input logic [15:0] lo);
      row_base = {hi, lo[15:IDX_W+1], {(IDX_W+1){1'b0}}};
   endfunction

   assign bus.reg_rdata = s_r.rdata;
   assign bus.stall     = s_r.busy;
   assign latch_word    = s_r.lword;
   assign row_addr      = s_r.row;
   assign op_erase      = s_r.erase;
   assign op_program    = s_r.prog;
   assign op_done       = s_r.done;

   always_comb begin
      s_nxt       = s_r;
      s_nxt.rdata = 16'h0000;
      s_nxt.done  = 1'b0;
      s_nxt.lword = s_r.latch[latch_idx];
      // ---------------------------------------------------------------
      // register reads, data in the following cycle
      // ---------------------------------------------------------------
      if (bus.reg_rd) begin
         case (bus.reg_addr)
            OFS_CTRL:    s_nxt.rdata = s_r.ctrl;
            OFS_ADDR_LO: s_nxt.rdata = s_r.adr_lo;
            OFS_ADDR_HI: s_nxt.rdata = {8'h00, s_r.adr_hi};
            default:     s_nxt.rdata = 16'h0000;
         endcase
      end
      // ---------------------------------------------------------------
      // register writes, ignored while an operation runs
      // ---------------------------------------------------------------
      if (bus.reg_wr && !s_r.busy) begin
         s_nxt.key = KEY_IDLE;
         case (bus.reg_addr)
            OFS_CTRL: begin
               s_nxt.ctrl = bus.reg_wdata & CTRL_WMASK;
               if (bus.reg_wdata[CTRL_GO] && s_r.key == KEY_OPEN && s_r.ctrl[CTRL_PERMIT]
                   && bus.reg_wdata[3:0] == OP_ROW) begin
                  s_nxt.ctrl[CTRL_GO] = 1'b1;
                  s_nxt.busy          = 1'b1;
                  s_nxt.cnt           = CNT_W'(OP_LEN - 1);
                  s_nxt.row           = row_base(s_r.adr_hi, s_r.adr_lo);
                  s_nxt.erase         = bus.reg_wdata[OP_ERASE_BIT];
                  s_nxt.prog          = !bus.reg_wdata[OP_ERASE_BIT];
               end else begin
                  s_nxt.ctrl[CTRL_GO] = 1'b0;
               end
            end
            OFS_ADDR_LO: s_nxt.adr_lo = bus.reg_wdata;
            OFS_ADDR_HI: s_nxt.adr_hi = bus.reg_wdata[7:0];
            OFS_KEY: begin
               if (bus.reg_wdata[7:0] == KEY_FIRST) begin
                  s_nxt.key = KEY_HALF;
               end else if (bus.reg_wdata[7:0] == KEY_SECOND && s_r.key == KEY_HALF) begin
                  s_nxt.key = KEY_OPEN;
               end
            end
            default: s_nxt.key = KEY_IDLE;
         endcase
      end
      // ---------------------------------------------------------------
      // table stores into the write latches
      // ---------------------------------------------------------------
      if ((bus.tbl_low || bus.tbl_high) && !s_r.busy) begin
         s_nxt.key    = KEY_IDLE;
         s_nxt.adr_lo = bus.tbl_ea[15:0];
         s_nxt.adr_hi = bus.tbl_ea[23:16];
         if (bus.tbl_low) begin
            s_nxt.latch[ea_index(bus.tbl_ea)][15:0] = bus.tbl_data;
         end
         if (bus.tbl_high) begin
            s_nxt.latch[ea_index(bus.tbl_ea)][23:16] = bus.tbl_data[7:0];
         end
      end
      // ---------------------------------------------------------------
      // operation timer, core held stalled until it expires
      // ---------------------------------------------------------------
      if (s_r.busy) begin
         if (s_r.cnt == '0) begin
            s_nxt.busy          = 1'b0;
            s_nxt.ctrl[CTRL_GO] = 1'b0;
            s_nxt.erase         = 1'b0;
            s_nxt.prog          = 1'b0;
            s_nxt.done          = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_r      <= '0;
         s_r.ctrl <= RST_CTRL;
         s_r.key  <= KEY_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// File: flash_row_chk.sv
`timescale 1ns/1ps
module flash_row_chk #(
   parameter int OP_LEN = flash_seq_pkg::OP_CYCLES
) (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic        tbl_low,
   input wire logic        tbl_high,
   input wire logic [23:0] tbl_ea,
   input wire logic        stall
);
   import flash_seq_pkg::*;
   // ------------
   // helper state
   // ------------
   logic [CNT_W-1:0] run_r;
   logic [1:0]       key_r;
   logic [15:0]      ctrl_r;
   logic             go_ok;
   logic             quiet;
   assign quiet = !reg_wr && !reg_rd && !tbl_low && !tbl_high;
   // go write that the device must accept
   assign go_ok = reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_GO] && !stall && key_r == 2'h2
                  && ctrl_r[CTRL_PERMIT] && ctrl_r[3:0] == OP_ROW;
   always_ff @(posedge mclk) begin
      if (rst) begin
         run_r  <= '0;
         key_r  <= 2'h0;
         ctrl_r <= 16'h0000;
      end else begin
         run_r <= stall ? run_r + 1'b1 : '0;
         if (!stall && (tbl_low || tbl_high)) begin
            key_r <= 2'h0;
         end else if (!stall && reg_wr) begin
            key_r <= (reg_addr != OFS_KEY) ? 2'h0 : (reg_wdata[7:0] == KEY_FIRST) ? 2'h1
                     : (reg_wdata[7:0] == KEY_SECOND && key_r == 2'h1) ? 2'h2 : 2'h0;
            if (reg_addr == OFS_CTRL) begin
               ctrl_r <= reg_wdata & CTRL_WMASK;
            end
         end
      end
   end
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_run_len;
      $fell(stall) |-> run_r == OP_LEN;
   endproperty
   a_run_len: assert property (p_run_len) else $error("stall length wrong");
   property p_go_start;
      go_ok |=> stall;
   endproperty
   a_go_start: assert property (p_go_start) else $error("armed go did not start");
   property p_start_armed;
      $rose(stall) |-> $past(go_ok);
   endproperty
   a_start_armed: assert property (p_start_armed) else $error("cycle without unlock");
   property p_go_reads;
      reg_rd && reg_addr == OFS_CTRL |=> reg_rdata[CTRL_GO] == $past(stall);
   endproperty
   a_go_reads: assert property (p_go_reads) else $error("go bit not tracking cycle");
   property p_unimpl;
      reg_rd && reg_addr == OFS_CTRL |=> (reg_rdata & ~(GO_SET | CTRL_WMASK)) == 16'h0000;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unused control bits set");
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   property p_erase_seq;
      reg_wr && reg_addr == OFS_CTRL && reg_wdata == CMD_ERASE_ROW |=> reg_wr && reg_addr == OFS_ADDR_HI
         ##1 reg_wr && reg_addr == OFS_ADDR_LO ##1 reg_wr && reg_addr == OFS_KEY && reg_wdata[7:0] == KEY_FIRST
         ##1 reg_wr && reg_addr == OFS_KEY && reg_wdata[7:0] == KEY_SECOND ##1 go_ok;
   endproperty
   a_erase_seq: assert property (p_erase_seq) else $error("erase set-up order wrong");
   property p_after_go;
      go_ok |=> quiet [*2];
   endproperty
   a_after_go: assert property (p_after_go) else $error("access right after go");
   property p_low_high;
      tbl_low |=> tbl_high && tbl_ea == $past(tbl_ea);
   endproperty
   a_low_high: assert property (p_low_high) else $error("latch store pair broken");
   property p_frozen;
      stall |-> quiet;
   endproperty
   a_frozen: assert property (p_frozen) else $error("core active while stalled");
   c_erase: cover property (go_ok && ctrl_r[OP_ERASE_BIT]);
   c_prog: cover property (go_ok && !ctrl_r[OP_ERASE_BIT]);
   c_done: cover property ($fell(stall));
endmodule

// File: program_flash_row_sequencer_tb_top.sv
`timescale 1ns/1ps
module program_flash_row_sequencer_tb_top;
   import flash_seq_pkg::*;
   localparam int          OP_LEN = 20;
   localparam logic [15:0] BASE   = 16'h6000;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  user_addr = 4'h0;
   logic [15:0] user_wdata = 16'h0000;
   logic        user_wr = 1'b0;
   logic        user_rd = 1'b0;
   logic [15:0] user_rdata;
   logic [4:0]  latch_idx = 5'h00;
   logic [23:0] latch_word;
   logic [23:0] row_addr;
   logic        op_erase;
   logic        op_program;
   logic        op_done;
   logic [23:0] got;
   int          miscompares = 0;
   int          checked = 0;
   int          cycles = 0;
   flash_seq_if link_if ();
   flash_seq_if probe_if ();
   always #5 mclk = ~mclk;
   // -------------
   // design ends
   // -------------
   flash_row_core flash_row_core_i (.mclk(mclk), .rst(rst), .user_addr(user_addr), .user_wdata(user_wdata),
      .user_wr(user_wr), .user_rd(user_rd), .user_rdata(user_rdata), .bus(link_if.core));
   flash_row_seq #(.OP_LEN(OP_LEN)) flash_row_seq_i (.mclk(mclk), .rst(rst), .bus(link_if.dev),
      .latch_idx(latch_idx), .latch_word(latch_word), .row_addr(row_addr), .op_erase(op_erase),
      .op_program(op_program), .op_done(op_done));
   // second device driven directly by the bench to break the unlock order
   flash_row_seq #(.OP_LEN(OP_LEN)) flash_row_seq_i_2 (.mclk(mclk), .rst(rst), .bus(probe_if.dev),
      .latch_idx(5'h00), .latch_word(), .row_addr(), .op_erase(), .op_program(), .op_done());
   flash_row_chk #(.OP_LEN(OP_LEN)) flash_row_chk_i (.mclk(mclk), .rst(rst), .reg_wr(link_if.reg_wr),
      .reg_rd(link_if.reg_rd), .reg_addr(link_if.reg_addr), .reg_wdata(link_if.reg_wdata),
      .reg_rdata(link_if.reg_rdata), .tbl_low(link_if.tbl_low), .tbl_high(link_if.tbl_high),
      .tbl_ea(link_if.tbl_ea), .stall(link_if.stall));
   // -------------
   // tasks
   // -------------
   task automatic stop_test();
      if (miscompares == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [23:0] seen, input logic [23:0] want);
      checked++;
      if (seen !== want) begin
         miscompares++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic uwr(input logic [3:0] a, input logic [15:0] d);
      user_addr  <= a;
      user_wdata <= d;
      user_wr    <= 1'b1;
      @(posedge mclk);
      user_wr    <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic urd(input logic [3:0] a);
      user_addr <= a;
      user_rd   <= 1'b1;
      @(posedge mclk);
      user_rd   <= 1'b0;
      @(negedge mclk);
      got = 24'(user_rdata);
      @(posedge mclk);
   endtask
   task automatic dwr(input logic [15:0] a, input logic [15:0] d);
      probe_if.reg_addr  <= a;
      probe_if.reg_wdata <= d;
      probe_if.reg_wr    <= 1'b1;
      @(posedge mclk);
      probe_if.reg_wr    <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic drd(input logic [15:0] a);
      probe_if.reg_addr <= a;
      probe_if.reg_rd   <= 1'b1;
      @(posedge mclk);
      probe_if.reg_rd   <= 1'b0;
      @(negedge mclk);
      got = 24'(probe_if.reg_rdata);
      @(posedge mclk);
   endtask
   task automatic t_load();
      uwr(H_ADDR_LO, BASE);
      uwr(H_ADDR_HI, 16'h0000);
      urd(H_ADDR_LO);
      check(got, {8'h00, BASE});
      uwr(H_CTRL, 16'h0004);
      for (int i = 0; i < ROW_WORDS; i++) begin
         uwr(H_DATA_LO, 16'h1000 + 16'(i));
         uwr(H_DATA_HI, 16'hff00 | 16'(i));
         repeat (2) @(posedge mclk);
      end
      urd(H_STATUS);
      check(24'(got[5:0]), 24'h000020);
      for (int i = 0; i < ROW_WORDS; i++) begin
         latch_idx <= 5'(i);
         @(posedge mclk);
         @(negedge mclk);
         check(latch_word, {8'(i), 16'h1000 + 16'(i)});
         @(posedge mclk);
      end
   endtask
   task automatic t_op(input logic [15:0] cmd, input logic erase);
      int n;
      n = 0;
      uwr(H_CTRL, cmd);
      while (link_if.stall !== 1'b1 && n < 40) begin
         @(negedge mclk);
         n++;
      end
      check(24'(op_erase), 24'(erase));
      check(24'(op_program), 24'(!erase));
      check(row_addr, {8'h00, BASE});
      n = 0;
      while (link_if.stall === 1'b1 && n < 100) begin
         n++;
         @(negedge mclk);
      end
      check(24'(n), 24'(OP_LEN));
      check(24'(op_done), 24'h000001);
      n = 0;
      got = '0;
      while (got[7] !== 1'b1 && n < 20) begin
         @(posedge mclk);
         urd(H_STATUS);
         n++;
      end
      check(24'(got[7]), 24'h000001);
      check(24'(got[8]), 24'h000000);
   endtask
   task automatic t_refuse();
      int n;
      probe_if.tbl_ea  <= 24'h123456;
      probe_if.tbl_low <= 1'b1;
      @(posedge mclk);
      probe_if.tbl_low <= 1'b0;
      @(posedge mclk);
      drd(OFS_ADDR_LO);
      check(got, 24'h003456);
      drd(OFS_ADDR_HI);
      check(got, 24'h000012);
      dwr(OFS_CTRL, 16'hffff);
      drd(OFS_CTRL);
      check(got, 24'h00417f);
      drd(OFS_KEY);
      check(got, 24'h000000);
      dwr(OFS_ADDR_HI, 16'hffff);
      drd(OFS_ADDR_HI);
      check(got, 24'h0000ff);
      drd(16'h0770);
      check(got, 24'h000000);
      dwr(OFS_CTRL, CMD_PROG_ROW);
      dwr(OFS_KEY, 16'h00aa);
      dwr(OFS_CTRL, GO_SET | CMD_PROG_ROW);
      drd(OFS_CTRL);
      check(got, 24'h004001);
      dwr(OFS_KEY, 16'h0055);
      dwr(OFS_ADDR_LO, 16'h0000);
      dwr(OFS_KEY, 16'h00aa);
      dwr(OFS_CTRL, GO_SET | CMD_PROG_ROW);
      check(24'(probe_if.stall), 24'h000000);
      dwr(OFS_KEY, 16'h0055);
      dwr(OFS_KEY, 16'h00aa);
      dwr(OFS_CTRL, GO_SET | CMD_PROG_ROW);
      drd(OFS_CTRL);
      check(got, 24'h00c001);
      dwr(OFS_CTRL, 16'h0000);
      n = 0;
      while (probe_if.stall === 1'b1 && n < 60) begin
         @(posedge mclk);
         n++;
      end
      drd(OFS_CTRL);
      check(got, 24'h004001);
   endtask
   // -------------
   // main sequence
   // -------------
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 6000) begin
         miscompares++;
         stop_test();
      end
   end
   initial begin
      probe_if.reg_wr = 1'b0;
      probe_if.reg_rd = 1'b0;
      probe_if.reg_addr = 16'h0000;
      probe_if.reg_wdata = 16'h0000;
      probe_if.tbl_low = 1'b0;
      probe_if.tbl_high = 1'b0;
      probe_if.tbl_ea = 24'h000000;
      probe_if.tbl_data = 16'h0000;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      urd(H_STATUS);
      check(got, 24'h000000);
      t_load();
      t_op(16'h0001, 1'b1);
      t_op(16'h0002, 1'b0);
      t_refuse();
      stop_test();
   end
endmodule
